// File: core/dma_opctl_pkg.sv
// Package for the DMA operation control block: offsets, fields, reset values and types.
package dma_opctl_pkg;
    // Register byte offsets on the Avalon-MM slave.
    localparam logic [3:0] OFS_OPCTL   = 4'h0;
    localparam logic [3:0] OFS_IRQ_ST  = 4'h4;
    localparam logic [3:0] OFS_IRQ_MSK = 4'h8;
    // Field positions inside the operation control word.
    localparam int PRIO_HI_BIT  = 25;
    localparam int PRIO_LO_BIT  = 24;
    localparam int ADDR_ERR_BIT = 18;
    localparam int NMI_BIT      = 17;
    localparam int RR_SEL_LSB   = 2;
    // Reset values.
    localparam logic [31:0] OPCTL_RESET = 32'h0000_0000;
    localparam logic [1:0]  IRQ_RESET   = 2'h0;
    // Interrupt status bit positions.
    localparam int IRQ_AE_BIT  = 0;
    localparam int IRQ_NMI_BIT = 1;
    // Channel count.
    localparam int NUM_CH = 4;

    // Priority modes.
    typedef enum logic [1:0]
    {
        PRIO_FIXED1 = 2'h0,
        PRIO_FIXED2 = 2'h1,
        PRIO_RR_SEL = 2'h2,
        PRIO_RR_ALL = 2'h3
    } prio_mode_e;

    // Avalon-MM request bundle.
    typedef struct packed
    {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } avs_req_s;

    // Channel-side event bundle.
    typedef struct packed
    {
        logic addr_err;
        logic nmi;
        logic unit_done;
    } ch_evt_s;
endpackage

// File: core/dma_opctl.sv
// Operation control word: channel priority arbiter and sticky address error and NMI flags.
`timescale 1ns/1ns
module dma_opctl
    import dma_opctl_pkg::*;
(
    input  wire logic                      CLK,
    input  wire logic                      RSTN,
    input  wire logic                      CE,
    input  wire dma_opctl_pkg::avs_req_s   AVS_REQ,
    output logic [31:0]                    AVS_READDATA,
    output logic                           AVS_WAITREQUEST,
    input  wire logic [3:0]                CH_REQ,
    input  wire logic [3:0]                CH_ENABLE,
    input  wire logic                      MASTER_ENABLE,
    input  wire dma_opctl_pkg::ch_evt_s    CH_EVT,
    input  wire logic                      NMI_PIN,
    output logic [3:0]                     CH_GRANT,
    output logic                           XFER_HALT,
    output logic                           IRQ
);
    import dma_opctl_pkg::*;

    logic [1:0]  prio_r;
    logic [3:0]  rr_sel_r;
    logic        ae_r;
    logic        nmi_seen_flag_r;
    logic        ae_seen_r;
    logic        nmi_seen_r;
    logic [1:0]  irq_st_r;
    logic [1:0]  irq_msk_r;
    logic        nmi_m_r;
    logic        nmi_s_r;
    logic        nmi_d_r;
    logic        busy_r;
    logic [1:0]  last_r;
    logic [3:0]  grant_r;
    logic [31:0] rdata_r;
    logic        ack_r;
    logic        acc;
    logic        wr_ctl;
    logic        rd_ctl;
    logic        nmi_evt;
    logic        halt;
    logic [3:0]  elig;
    logic [3:0]  grant_nxt;
    logic [1:0]  win;
    logic [31:0] ctl_word;

    // Requests are answered one cycle after they appear, so waitrequest is high for the first cycle.
    assign acc    = CE && (AVS_REQ.read || AVS_REQ.write) && !ack_r;
    assign wr_ctl = acc && AVS_REQ.write && AVS_REQ.address == OFS_OPCTL;
    assign rd_ctl = acc && AVS_REQ.read && AVS_REQ.address == OFS_OPCTL;
    assign AVS_WAITREQUEST = (AVS_REQ.read || AVS_REQ.write) && !ack_r;
    assign AVS_READDATA    = rdata_r;

    // The NMI pin is asynchronous, so it passes two flops before edge detection.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            nmi_m_r <= 1'b0;
            nmi_s_r <= 1'b0;
            nmi_d_r <= 1'b0;
        end
        else if (CE)
        begin
            nmi_m_r <= NMI_PIN;
            nmi_s_r <= nmi_m_r;
            nmi_d_r <= nmi_s_r;
        end
    end
    assign nmi_evt = (nmi_s_r && !nmi_d_r) || CH_EVT.nmi;

    // Read data; reserved bits including 23 to 19 return zero.
    // reserved zero
    always_comb
    begin
        ctl_word = OPCTL_RESET;
        ctl_word[PRIO_HI_BIT:PRIO_LO_BIT] = prio_r;
        ctl_word[ADDR_ERR_BIT] = ae_r;
        ctl_word[NMI_BIT] = nmi_seen_flag_r;
        ctl_word[RR_SEL_LSB +: NUM_CH] = {rr_sel_r[0], rr_sel_r[1], rr_sel_r[2], rr_sel_r[3]};
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            rdata_r <= 32'h0000_0000;
            ack_r   <= 1'b0;
        end
        else if (CE)
        begin
            ack_r <= acc;
            if (acc && AVS_REQ.read)
            begin
                unique case (AVS_REQ.address)
                    OFS_OPCTL:   rdata_r <= ctl_word;
                    OFS_IRQ_ST:  rdata_r <= {30'h0, irq_st_r};
                    OFS_IRQ_MSK: rdata_r <= {30'h0, irq_msk_r};
                    default:     rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Priority mode and round-robin selects; writes to reserved bits are dropped.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            prio_r   <= OPCTL_RESET[PRIO_HI_BIT:PRIO_LO_BIT];
            rr_sel_r <= 4'h0;
        end
        else if (wr_ctl)
        begin
            prio_r   <= AVS_REQ.writedata[PRIO_HI_BIT:PRIO_LO_BIT];
            rr_sel_r <= {AVS_REQ.writedata[RR_SEL_LSB], AVS_REQ.writedata[RR_SEL_LSB+1],
                         AVS_REQ.writedata[RR_SEL_LSB+2], AVS_REQ.writedata[RR_SEL_LSB+3]};
        end
    end

    // Sticky address error flag; a read of one arms the clear, and a fresh error disarms it so none is lost.
    // set on error
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            ae_r      <= 1'b0;
            ae_seen_r <= 1'b0;
        end
        else if (CE)
        begin
            if (CH_EVT.addr_err)
                ae_r <= 1'b1;
            else if (wr_ctl && !AVS_REQ.writedata[ADDR_ERR_BIT] && ae_seen_r)
                ae_r <= 1'b0;
            if (rd_ctl && ae_r && !CH_EVT.addr_err)
                ae_seen_r <= 1'b1;
            else if (wr_ctl || !ae_r || CH_EVT.addr_err)
                ae_seen_r <= 1'b0;
        end
    end

    // Sticky NMI flag, set whether or not a transfer is running.
    // set on NMI
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            nmi_seen_flag_r     <= 1'b0;
            nmi_seen_r <= 1'b0;
        end
        else if (CE)
        begin
            if (nmi_evt)
                nmi_seen_flag_r <= 1'b1;
            else if (wr_ctl && !AVS_REQ.writedata[NMI_BIT] && nmi_seen_r)
                nmi_seen_flag_r <= 1'b0;
            if (rd_ctl && nmi_seen_flag_r && !nmi_evt)
                nmi_seen_r <= 1'b1;
            else if (wr_ctl || !nmi_seen_flag_r || nmi_evt)
                nmi_seen_r <= 1'b0;
        end
    end

    // Interrupt status, write one to clear, event wins; mask gates the level output.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            irq_st_r  <= IRQ_RESET;
            irq_msk_r <= IRQ_RESET;
        end
        else if (CE)
        begin
            if (acc && AVS_REQ.write && AVS_REQ.address == OFS_IRQ_MSK)
                irq_msk_r <= AVS_REQ.writedata[1:0];
            irq_st_r[IRQ_AE_BIT] <= CH_EVT.addr_err || (irq_st_r[IRQ_AE_BIT] &&
                !(acc && AVS_REQ.write && AVS_REQ.address == OFS_IRQ_ST && AVS_REQ.writedata[IRQ_AE_BIT]));
            irq_st_r[IRQ_NMI_BIT] <= nmi_evt || (irq_st_r[IRQ_NMI_BIT] &&
                !(acc && AVS_REQ.write && AVS_REQ.address == OFS_IRQ_ST && AVS_REQ.writedata[IRQ_NMI_BIT]));
        end
    end
    assign IRQ = |(irq_st_r & irq_msk_r);

    // Halt: either flag stops new starts on all channels.
    // halt all
    assign halt      = ae_r || nmi_seen_flag_r;
    assign XFER_HALT = halt;
    assign elig      = CH_REQ & CH_ENABLE & {NUM_CH{MASTER_ENABLE && !halt}};

    // Winner selection by priority mode.
    // mode select
    always_comb
    begin
        grant_nxt = 4'h0;
        win       = 2'h0;
        unique case (prio_mode_e'(prio_r))
            PRIO_FIXED1:
            begin
                for (int i = NUM_CH - 1; i >= 0; i--)
                    if (elig[i])
                        win = 2'(i);
            end
            PRIO_FIXED2:
            begin
                if (elig[1]) win = 2'h1;
                if (elig[3]) win = 2'h3;
                if (elig[2]) win = 2'h2;
                if (elig[0]) win = 2'h0;
            end
            PRIO_RR_SEL:
            begin
                for (int k = NUM_CH; k >= 1; k--)
                    if (elig[2'(last_r + 2'(k))] && rr_sel_r[2'(last_r + 2'(k))])
                        win = 2'(last_r + 2'(k));
                if (!(|(elig & rr_sel_r)))
                    for (int i = NUM_CH - 1; i >= 0; i--)
                        if (elig[i])
                            win = 2'(i);
            end
            PRIO_RR_ALL:
            begin
                for (int k = NUM_CH; k >= 1; k--)
                    if (elig[2'(last_r + 2'(k))])
                        win = 2'(last_r + 2'(k));
            end
        endcase
        if (|elig)
            grant_nxt[win] = 1'b1;
    end

    // Grant holds for one transfer unit; a pending NMI lets that unit finish first.
    // finish unit
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            grant_r    <= 4'h0;
            busy_r     <= 1'b0;
            last_r     <= 2'h3;
        end
        else if (CE)
        begin
            if (wr_ctl)
                last_r <= 2'h3;
            if (busy_r)
            begin
                if (CH_EVT.unit_done || CH_EVT.addr_err)
                begin
                    grant_r    <= 4'h0;
                    busy_r     <= 1'b0;
                end
            end
            else if (|grant_nxt)
            begin
                grant_r <= grant_nxt;
                busy_r  <= 1'b1;
                last_r  <= win;
            end
        end
    end
    assign CH_GRANT = grant_r;

    // Assertions.
    property p_halt_blocks;
        @(posedge CLK) disable iff (!RSTN) (halt && !busy_r) |=> !busy_r;
    endproperty
    a_halt_blocks: assert property (p_halt_blocks) else $error("Transfer started while halted.");

    property p_ae_set;
        @(posedge CLK) disable iff (!RSTN) (CE && CH_EVT.addr_err) |=> ae_r;
    endproperty
    a_ae_set: assert property (p_ae_set) else $error("Address error flag not set.");

    property p_fixed1;
        @(posedge CLK) disable iff (!RSTN) (CE && !busy_r && prio_r == 2'h0 && elig[0]) |=> grant_r == 4'h1;
    endproperty
    a_fixed1: assert property (p_fixed1) else $error("Fixed order one lost channel 0.");

    property p_fixed2;
        @(posedge CLK) disable iff (!RSTN)
            (CE && !busy_r && prio_r == 2'h1 && elig == 4'ha) |=> grant_r == 4'h8;
    endproperty
    a_fixed2: assert property (p_fixed2) else $error("Fixed order two did not prefer channel 3 over 1.");

    property p_rr_all;
        @(posedge CLK) disable iff (!RSTN)
            (CE && !busy_r && prio_r == 2'h3 && elig == 4'hf) |=> grant_r[$past(last_r) + 2'h1];
    endproperty
    a_rr_all: assert property (p_rr_all) else $error("Round robin did not advance.");

    property p_ae_no_one;
        @(posedge CLK) disable iff (!RSTN) (!ae_r && !CH_EVT.addr_err) |=> !ae_r;
    endproperty
    a_ae_no_one: assert property (p_ae_no_one) else $error("Address error flag set by software.");

    property p_nmi_set;
        @(posedge CLK) disable iff (!RSTN) (CE && nmi_evt) |=> nmi_seen_flag_r;
    endproperty
    a_nmi_set: assert property (p_nmi_set) else $error("NMI flag not set.");

    property p_reserved;
        @(posedge CLK) disable iff (!RSTN) ctl_word[23:19] == 5'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bits not zero.");

    property p_unread_keep;
        @(posedge CLK) disable iff (!RSTN) (nmi_seen_flag_r && !nmi_seen_r) |=> nmi_seen_flag_r;
    endproperty
    a_unread_keep: assert property (p_unread_keep) else $error("NMI flag cleared without a read.");
endmodule // dma_opctl

// File: bench/ch_engine_model.sv
// Behavioural channel engine that ends each granted unit with a done or an address error pulse.
`timescale 1ns/1ns
module ch_engine_model
    import dma_opctl_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic [3:0]        CH_GRANT,
    input  wire logic              FAULT,
    input  wire logic [3:0]        LAT,
    output dma_opctl_pkg::ch_evt_s CH_EVT
);
    import dma_opctl_pkg::*;
    logic [3:0] busy_r;

    // Count cycles under a grant; the count restarts when the grant drops, so one unit gives one pulse.
    // unit completion
    always_ff @(posedge CLK)
    begin
        CH_EVT <= '0;
        if (CH_GRANT == 4'h0)
            busy_r <= 4'h0;
        else if (busy_r == LAT)
        begin
            busy_r <= 4'h0;
            CH_EVT.addr_err <= FAULT;
            CH_EVT.unit_done <= !FAULT;
        end
        else
            busy_r <= busy_r + 4'h1;
    end
endmodule // ch_engine_model

// File: bench/tb_top.sv
// Register, arbitration and halt-flag tests for the operation control block.
`timescale 1ns/1ns
module tb_top;
    import dma_opctl_pkg::*;
    logic CLK = 1'b0, RSTN = 1'b0, MASTER_ENABLE = 1'b0, NMI_PIN = 1'b0, fault = 1'b0;
    logic [3:0] CH_REQ = 4'h0, CH_ENABLE = 4'h0, CH_GRANT, lat = 4'h2, g;
    logic [31:0] AVS_READDATA, q;
    logic AVS_WAITREQUEST, XFER_HALT, IRQ;
    avs_req_s req = '0;
    ch_evt_s evt;
    int n_mismatch = 0, total_checks = 0;
    logic [47:0] prio_tab [6] = '{48'h0000_0000_e222, 48'h0000_003c_f111, 48'h0100_0000_e444,
                                 48'h0100_0000_a888, 48'h0300_0000_f124, 48'h0200_0014_f282};

    dma_opctl dut (.CLK(CLK), .RSTN(RSTN), .CE(1'b1), .AVS_REQ(req), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .CH_REQ(CH_REQ), .CH_ENABLE(CH_ENABLE),
        .MASTER_ENABLE(MASTER_ENABLE), .CH_EVT(evt), .NMI_PIN(NMI_PIN), .CH_GRANT(CH_GRANT),
        .XFER_HALT(XFER_HALT), .IRQ(IRQ));
    ch_engine_model engines (.CLK(CLK), .CH_GRANT(CH_GRANT), .FAULT(fault), .LAT(lat), .CH_EVT(evt));

    // Free-running 250 MHz clock.
    initial
    begin
        forever #2 CLK = ~CLK;
    end

    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon-MM access; the request is held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge CLK);
        req <= '{address: adr, read: !wr, write: wr, writedata: wd};
        // No cycle count is assumed; the watchdog ends a wait that never completes.
        do
            @(posedge CLK);
        while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        req <= '0;
    endtask

    task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
        bus(1'b1, adr, wd, q);
    endtask

    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0, q);
        chk(q, exp);
    endtask

    // Waits for the next grant and then for it to drop again; the watchdog bounds both waits.
    task automatic get_grant(output logic [3:0] gr);
        do
            @(posedge CLK);
        while (CH_GRANT === 4'h0);
        gr = CH_GRANT;
        while (CH_GRANT !== 4'h0)
            @(posedge CLK);
    endtask

    // Confirms that no grant is issued for a number of cycles.
    task automatic no_grant(input int cyc);
        repeat (cyc)
        begin
            @(posedge CLK);
            chk({28'h0, CH_GRANT}, 32'h0);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need.
    initial
    begin
        #100000;
        n_mismatch++;
        give_verdict();
    end

    // Main sequence.
    initial
    begin
        repeat (5) @(posedge CLK);
        RSTN <= 1'b1;
        rd_chk(OFS_OPCTL, OPCTL_RESET);
        // Software keeps the reserved positions at zero; the readback must show them still clear.
        wr(OFS_OPCTL, 32'h0300_003c);
        rd_chk(OFS_OPCTL, 32'h0300_003c);
        $display("test registers done");
        CH_ENABLE <= 4'hf;
        MASTER_ENABLE <= 1'b1;
        // Each row: control word, requests, then three expected grants in order.
        foreach (prio_tab[i])
        begin
            wr(OFS_OPCTL, prio_tab[i][47:16]);
            CH_REQ <= prio_tab[i][15:12];
            for (int k = 2; k >= 0; k--)
            begin
                get_grant(g);
                chk({28'h0, g}, {28'h0, prio_tab[i][k*4 +: 4]});
            end
            CH_REQ <= 4'h0;
            repeat (2) @(posedge CLK);
        end
        $display("test priority done");
        wr(OFS_OPCTL, 32'h0);
        wr(OFS_IRQ_MSK, 32'h3);
        fault <= 1'b1;
        CH_REQ <= 4'h1;
        get_grant(g);
        fault <= 1'b0;
        chk({31'h0, XFER_HALT}, 32'h1);
        chk({31'h0, IRQ}, 32'h1);
        no_grant(8);
        wr(OFS_OPCTL, 32'h0);
        rd_chk(OFS_OPCTL, 32'h0004_0000);
        wr(OFS_OPCTL, 32'h0);
        rd_chk(OFS_OPCTL, 32'h0);
        wr(OFS_OPCTL, 32'h0004_0000);
        rd_chk(OFS_OPCTL, 32'h0);
        wr(OFS_IRQ_MSK, 32'h0);
        chk({31'h0, IRQ}, 32'h0);
        wr(OFS_IRQ_MSK, 32'h1);
        chk({31'h0, IRQ}, 32'h1);
        wr(OFS_IRQ_ST, 32'h1);
        chk({31'h0, IRQ}, 32'h0);
        rd_chk(OFS_IRQ_ST, 32'h0);
        $display("test address error done");
        lat <= 4'h9;
        get_grant(g);
        @(posedge CLK);
        while (CH_GRANT === 4'h0)
            @(posedge CLK);
        NMI_PIN <= 1'b1;
        repeat (2) @(posedge CLK);
        NMI_PIN <= 1'b0;
        repeat (2) @(posedge CLK);
        chk({28'h0, CH_GRANT}, 32'h1);
        while (CH_GRANT !== 4'h0)
            @(posedge CLK);
        @(posedge CLK);
        chk({31'h0, XFER_HALT}, 32'h1);
        no_grant(8);
        rd_chk(OFS_OPCTL, 32'h0002_0000);
        wr(OFS_OPCTL, 32'h0);
        rd_chk(OFS_OPCTL, 32'h0);
        get_grant(g);
        chk({28'h0, g}, 32'h1);
        CH_REQ <= 4'h0;
        $display("test nmi done");
        give_verdict();
    end
endmodule // tb_top
